//--- src/spi_pkg.sv
// constants for the serial port status and data unit
package spi_pkg;
	localparam int ADDR_W = 12;
	// register byte offsets
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] DATA_OFFSET = 12'h008;
	// control register fields
	localparam int CTRL_IE_BIT = 7;
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_MASTER_BIT = 4;
	localparam int CTRL_CPOL_BIT = 3;
	localparam int CTRL_CPHA_BIT = 2;
	localparam int CTRL_RATE_HI = 1;
	localparam int CTRL_RATE_LO = 0;
	localparam logic [7:0] CTRL_WMASK = 8'hdf;
	// status register fields
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_COL_BIT = 6;
	localparam int STAT_DBL_BIT = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	// one byte is sixteen clock edges
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	// half serial clock periods in cpu clocks: divide by 4, 16, 64, 128
	localparam logic [6:0] HALF_DIV4 = 7'h02;
	localparam logic [6:0] HALF_DIV16 = 7'h08;
	localparam logic [6:0] HALF_DIV64 = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
	localparam logic [1:0] RATE_DIV16 = 2'h1;
endpackage

//--- src/spi_rate_if.sv
// carrier between the shift engine and the serial clock rate generator
interface spi_rate_if;
	logic run;
	logic [1:0] rate_sel;
	logic dbl;
	logic tick;
	modport gen (input run, input rate_sel, input dbl, output tick);
	modport user (output run, output rate_sel, output dbl, input tick);
endinterface

//--- src/spi_rate_gen.sv
// serial clock half-period tick generator
module spi_rate_gen (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	spi_rate_if.gen rate
);
	logic [6:0] cnt_reg;
	logic [6:0] half;

	always_comb begin
		unique case (rate.rate_sel)
			2'h0: half = spi_pkg::HALF_DIV4;
			2'h1: half = spi_pkg::HALF_DIV16;
			2'h2: half = spi_pkg::HALF_DIV64;
			2'h3: half = spi_pkg::HALF_DIV128;
		endcase
		// double speed halves the period, least two cpu clocks per bit
		if (rate.dbl) begin
			half = half >> 1;
		end
	end

	assign rate.tick = rate.run && (cnt_reg == half - 7'h01);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 7'h00;
		end else if (ce) begin
			if (!rate.run || rate.tick) begin
				cnt_reg <= 7'h00;
			end else begin
				cnt_reg <= cnt_reg + 7'h01;
			end
		end
	end
endmodule

//--- src/spi_status_data_unit.sv
// serial peripheral port: apb registers, status flags and byte shift engine
//////////////////////////////////////////////////////////////////////////////
module spi_status_data_unit (
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic global_int_enable,
	input wire logic int_vector_taken,
	output logic int_request,
	input wire logic ss_is_input,
	input wire logic ss_n_in,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe
);
	//////////////////////////////////////////////////////////////////////////
	// reset release
	logic [1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	//////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] ctrl_reg;
	logic done_reg;
	logic col_reg;
	logic dbl_reg;
	logic [7:0] rx_buf_reg;
	logic done_armed_reg;
	logic col_armed_reg;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [4:0] edge_cnt_reg;
	logic sample_bit_reg;
	logic sck_level_reg;
	logic sck_prev_reg;
	logic master_run_reg;

	logic port_en;
	logic is_master;
	logic cpol;
	logic cpha;
	logic access;
	logic wr;
	logic rd;
	logic sel_ctrl;
	logic sel_status;
	logic sel_data;
	logic data_access;
	logic busy;
	logic data_write;
	logic start;
	logic ss_fault;
	logic edge_ev;
	logic new_level;
	logic leading;
	logic sample_edge;
	logic serial_in;
	logic last_edge;
	logic byte_done;

	spi_rate_if rate ();

	spi_rate_gen u_rate (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.rate(rate)
	);

	assign port_en = ctrl_reg[spi_pkg::CTRL_EN_BIT];
	assign is_master = ctrl_reg[spi_pkg::CTRL_MASTER_BIT];
	assign cpol = ctrl_reg[spi_pkg::CTRL_CPOL_BIT];
	assign cpha = ctrl_reg[spi_pkg::CTRL_CPHA_BIT];

	//////////////////////////////////////////////////////////////////////////
	// apb decode; zero wait states, a frozen clock stretches the access
	assign access = psel && penable && ce;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign sel_ctrl = paddr == spi_pkg::CTRL_OFFSET;
	assign sel_status = paddr == spi_pkg::STATUS_OFFSET;
	assign sel_data = paddr == spi_pkg::DATA_OFFSET;
	assign data_access = access && sel_data;
	assign pready = ce;
	assign pslverr = psel && penable && !(sel_ctrl || sel_status || sel_data);

	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			if (sel_ctrl) begin
				prdata[7:0] = ctrl_reg;
			end else if (sel_status) begin
				// reserved bits stay zero
				prdata[spi_pkg::STAT_DONE_BIT] = done_reg;
				prdata[spi_pkg::STAT_COL_BIT] = col_reg;
				prdata[spi_pkg::STAT_DBL_BIT] = dbl_reg;
			end else if (sel_data) begin
				prdata[7:0] = rx_buf_reg;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// transfer control
	assign busy = is_master ? master_run_reg : (edge_cnt_reg != 5'h00);
	assign data_write = wr && sel_data;
	// a write while busy is dropped and flagged instead
	assign start = data_write && !busy && port_en && is_master;
	assign ss_fault = port_en && is_master && ss_is_input && !ss_n_in;

	assign rate.run = master_run_reg;
	assign rate.rate_sel = ctrl_reg[spi_pkg::CTRL_RATE_HI:spi_pkg::CTRL_RATE_LO];
	assign rate.dbl = dbl_reg;

	// master edges come from the rate generator, slave edges from the pin;
	// the pin is sampled directly, so the external clock must stay slow
	always_comb begin
		if (is_master) begin
			edge_ev = master_run_reg && rate.tick;
			new_level = !sck_level_reg;
		end else begin
			edge_ev = port_en && !ss_n_in && (sck_in != sck_prev_reg);
			new_level = sck_in;
		end
	end

	// leading edge leaves the idle level; phase picks the sampling edge
	assign leading = new_level != cpol;
	assign sample_edge = leading ^ cpha;
	assign serial_in = is_master ? miso_in : mosi_in;
	assign last_edge = edge_cnt_reg == spi_pkg::EDGES_PER_BYTE - 5'h01;
	assign byte_done = edge_ev && last_edge;

	// sampled bit enters on the next shift edge, but a sample on the last edge enters at once, so the output bit stays stable
	always_comb begin
		shift_next = shift_reg;
		if (edge_ev) begin
			if (last_edge && sample_edge) begin
				shift_next = {shift_reg[6:0], serial_in};
			end else if (!sample_edge && !(cpha && edge_cnt_reg == 5'h00)) begin
				shift_next = {shift_reg[6:0], sample_bit_reg};
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= spi_pkg::REG_RESET;
			sample_bit_reg <= 1'b0;
		end else if (ce) begin
			if (start || (data_write && !busy && !is_master)) begin
				shift_reg <= pwdata[7:0];
			end else begin
				shift_reg <= shift_next;
			end
			if (edge_ev && sample_edge) begin
				sample_bit_reg <= serial_in;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt_reg <= 5'h00;
			master_run_reg <= 1'b0;
		end else if (ce) begin
			if (!port_en || ss_fault || (!is_master && ss_n_in)) begin
				edge_cnt_reg <= 5'h00;
				master_run_reg <= 1'b0;
			end else if (byte_done) begin
				edge_cnt_reg <= 5'h00;
				master_run_reg <= 1'b0;
			end else begin
				if (edge_ev) begin
					edge_cnt_reg <= edge_cnt_reg + 5'h01;
				end
				if (start) begin
					master_run_reg <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sck_level_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
		end else if (ce) begin
			sck_prev_reg <= sck_in;
			if (!master_run_reg) begin
				sck_level_reg <= cpol;
			end else if (edge_ev) begin
				sck_level_reg <= new_level;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_buf_reg <= spi_pkg::REG_RESET;
		end else if (ce && byte_done) begin
			rx_buf_reg <= shift_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// control and double speed bits
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= spi_pkg::REG_RESET;
			dbl_reg <= 1'b0;
		end else if (ce) begin
			if (wr && sel_ctrl) begin
				ctrl_reg <= pwdata[7:0] & spi_pkg::CTRL_WMASK;
			end
			if (wr && sel_status) begin
				dbl_reg <= pwdata[spi_pkg::STAT_DBL_BIT];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// status flags; a new event in the clearing cycle wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			done_armed_reg <= 1'b0;
			col_armed_reg <= 1'b0;
		end else if (ce) begin
			if (rd && sel_status) begin
				done_armed_reg <= done_reg;
				col_armed_reg <= col_reg;
			end else if (data_access) begin
				done_armed_reg <= 1'b0;
				col_armed_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else if (ce) begin
			if (byte_done || ss_fault) begin
				done_reg <= 1'b1;
			end else if (int_request && int_vector_taken) begin
				done_reg <= 1'b0;
			end else if (data_access && (done_armed_reg || col_armed_reg)) begin
				done_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			col_reg <= 1'b0;
		end else if (ce) begin
			if (data_write && busy) begin
				col_reg <= 1'b1;
			end else if (data_access && col_armed_reg) begin
				col_reg <= 1'b0;
			end
		end
	end

	assign int_request = done_reg && ctrl_reg[spi_pkg::CTRL_IE_BIT]
		&& global_int_enable;

	//////////////////////////////////////////////////////////////////////////
	// pins
	assign sck_out = sck_level_reg;
	assign sck_oe = port_en && is_master;
	assign mosi_out = shift_reg[7];
	assign mosi_oe = port_en && is_master;
	assign miso_out = shift_reg[7];
	assign miso_oe = port_en && !is_master && !ss_n_in;
endmodule

//--- test/spi_slave_model.sv
// behavioural far-side slave: one byte in and one byte out per eight clock pairs
module spi_slave_model (
	input wire logic clock,
	input wire logic load,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic sck,
	input wire logic mosi,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sck_q = 1'b0;
	logic [2:0] cnt = 3'h0;
	// edges are seen one cpu clock late, so half periods under two clocks are too fast
	always_ff @(posedge clock) begin
		sck_q <= sck;
		if (load)
			cnt <= 3'h0;
		else if (sck != sck_q && ((sck != cpol) ^ cpha))
			rx <= {rx[6:0], mosi};
		else if (sck != sck_q)
			cnt <= cnt + 3'h1;
	end
	assign miso = tx[3'h7 - cnt + {2'h0, cpha}];
endmodule

//--- test/spi_sdu_sva.sv
// concurrent checks on the serial port unit's pins and register reads
module spi_sdu_sva (
	input wire logic clock,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic global_int_enable,
	input wire logic int_vector_taken,
	input wire logic int_request,
	input wire logic ss_is_input,
	input wire logic ss_n_in,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] tog;
	logic [1:0] wr_q;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// control writes move the idle level; those toggles belong to no byte.
	// the new level shows two edges after the write, so the mask lasts two cycles
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tog <= 5'h00;
			wr_q <= 2'h0;
		end else begin
			wr_q <= {wr_q[0], psel && pwrite && paddr == spi_pkg::CTRL_OFFSET};
			if (int_request || (|wr_q) || (psel && pwrite && paddr == spi_pkg::CTRL_OFFSET))
				tog <= 5'h00;
			else if ($changed(sck_out))
				tog <= tog + 5'h01;
		end
	end
	chk_irq_gated: assert property (int_request |-> global_int_enable)
		else $error("irq without global enable");
	chk_byte_edges: assert property ($rose(int_request) && !ss_is_input |->
		tog + {4'h0, $changed(sck_out)} == 5'h10)
		else $error("done not at 16th edge");
	chk_fault_sets: assert property (ce && ss_is_input && !ss_n_in && sck_oe && global_int_enable
		|-> ##[0:3] int_request)
		else $error("select fault not flagged");
	chk_vector_clear: assert property (int_vector_taken && int_request &&
		!(ss_is_input && !ss_n_in) |=> !int_request)
		else $error("vector left done set");
	chk_irq_hold: assert property ($fell(int_request) && global_int_enable |->
		$past(int_vector_taken) || $past(psel))
		else $error("done dropped alone");
	chk_reserved_zero: assert property (psel && !pwrite && paddr == spi_pkg::STATUS_OFFSET
		|-> prdata[5:1] == 5'h00)
		else $error("reserved bits set");
	chk_miso_select: assert property (miso_oe |-> !ss_n_in && !sck_oe)
		else $error("miso driven unselected");
	chk_reset_idle: assert property ($rose(resetn) |-> !sck_oe && !mosi_oe && !int_request)
		else $error("port busy after reset");
endmodule
bind spi_status_data_unit spi_sdu_sva i_spi_sdu_sva (.clock, .resetn, .ce, .psel, .pwrite, .paddr,
	.prdata, .global_int_enable, .int_vector_taken, .int_request, .ss_is_input, .ss_n_in,
	.sck_out, .sck_oe, .mosi_oe, .miso_oe);

//--- test/tb.sv
// bench: register access, master transfers in four formats, flag clearing
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] CTRL = spi_pkg::CTRL_OFFSET;
	localparam logic [11:0] STAT = spi_pkg::STATUS_OFFSET;
	localparam logic [11:0] DATA = spi_pkg::DATA_OFFSET;
	logic clock = 1'b0, resetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic global_int_enable = 1'b1, int_vector_taken = 1'b0, ss_is_input = 1'b0, ss_n_in = 1'b1;
	logic load = 1'b0, cpol = 1'b0, cpha = 1'b0, pready, pslverr, int_request, err, smiso;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic [7:0] stx = 8'h00, srx, rd;
	int fail_count = 0, tests_run = 0, n;
	always #5 clock = ~clock;
	spi_status_data_unit i_spi_status_data_unit (.clock, .resetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .global_int_enable, .int_vector_taken,
		.int_request, .ss_is_input, .ss_n_in, .sck_in(sck_out), .sck_out, .sck_oe,
		.mosi_in(mosi_out), .mosi_out, .mosi_oe, .miso_in(miso_oe ? miso_out : smiso),
		.miso_out, .miso_oe);
	spi_slave_model i_spi_slave_model (.clock, .load, .cpol, .cpha, .sck(sck_out),
		.mosi(mosi_out), .tx(stx), .miso(smiso), .rx(srx));
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic hang();
		fail_count++;
		$display("unexpected at %0t: wait ran out", $time);
		print_verdict();
	endtask
	task automatic rw(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (n == 50)
			hang();
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_irq();
		for (n = 0; n < 3000 && int_request !== 1'b1; n++)
			@(posedge clock);
		if (n == 3000)
			hang();
	endtask
	initial begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		rw(1'b0, STAT, 8'h00);
		check(rd, 8'h00);
		rw(1'b1, STAT, 8'hff);
		rw(1'b0, STAT, 8'h00);
		check(rd, 8'h01);
		rw(1'b0, 12'h00c, 8'h00);
		check({rd[6:0], err}, 8'h01);
		$display("registers done");
		// the fifth pass repeats the first format at double speed
		for (int m = 0; m < 5; m++) begin
			int h;
			h = (m == 4) ? 4 : 8;
			cpol <= m[1];
			cpha <= m[0];
			stx <= 8'h5a + 8'(m);
			load <= 1'b1;
			rw(1'b1, CTRL, 8'hd1 | {4'h0, m[1:0], 2'h0});
			rw(1'b1, STAT, {7'h00, m == 4});
			load <= 1'b0;
			rw(1'b1, DATA, 8'h93 ^ 8'(m));
			wait_irq();
			check({7'h00, n > 16 * h - 4 && n < 16 * h + 4}, 8'h01);
			rw(1'b0, STAT, 8'h00);
			check(rd, {1'b1, 6'h00, m == 4});
			rw(1'b0, DATA, 8'h00);
			check(rd, 8'h5a + 8'(m));
			check(srx, 8'h93 ^ 8'(m));
			rw(1'b0, STAT, 8'h00);
			check(rd, {7'h00, m == 4});
		end
		$display("transfers done");
		rw(1'b1, DATA, 8'h0f);
		rw(1'b1, DATA, 8'hf0);
		rw(1'b0, STAT, 8'h00);
		check(rd, 8'h41);
		wait_irq();
		rw(1'b0, STAT, 8'h00);
		check(rd, 8'hc1);
		rw(1'b0, DATA, 8'h00);
		check(srx, 8'h0f);
		rw(1'b0, STAT, 8'h00);
		check(rd, 8'h01);
		$display("collision done");
		// a frozen clock enable must hold the fault off the done flag
		ce <= 1'b0;
		ss_is_input <= 1'b1;
		ss_n_in <= 1'b0;
		repeat (4) @(posedge clock);
		check({7'h00, int_request}, 8'h00);
		ce <= 1'b1;
		wait_irq();
		rw(1'b0, STAT, 8'h00);
		check(rd, 8'h81);
		global_int_enable <= 1'b0;
		repeat (2) @(posedge clock);
		check({7'h00, int_request}, 8'h00);
		global_int_enable <= 1'b1;
		ss_n_in <= 1'b1;
		@(posedge clock);
		int_vector_taken <= 1'b1;
		@(posedge clock);
		int_vector_taken <= 1'b0;
		rw(1'b0, STAT, 8'h00);
		check(rd, 8'h01);
		$display("fault done");
		print_verdict();
	end
endmodule
